// [vof_fifo.sv]
// Synchronous FIFO with a registered read word.
// Assumes DEPTH is a power of two; one clock, async low reset.
module vof_fifo #(
  parameter int W     = 42,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_ready,
  // Drain side
  output logic              rd_valid,
  output logic [W-1:0]      rd_data,
  input  wire logic         rd_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          room_r;
  logic          rv_r;
  logic [W-1:0]  rd_r;
  logic          push;
  logic          load;

  // Room is a flop so the source sees a clean ready, no inverter
  assign push     = wr_valid && room_r;
  assign load     = (cnt_r != '0) && (!rv_r || rd_ready);
  assign wr_ready = room_r;
  assign rd_valid = rv_r;
  assign rd_data  = rd_r;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= wr_data;
    end
  end

  // Occupancy
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !load) begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end else if (load && !push) begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
  end

  // Pointers and counters
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r   <= '0;
      rp_r   <= '0;
      cnt_r  <= '0;
      room_r <= 1'b1;
    end else begin
      if (push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (load) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r  <= cnt_nxt;
      room_r <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end

  // Read word held in a register until taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rv_r <= 1'b0;
      rd_r <= '0;
    end else if (load) begin
      rv_r <= 1'b1;
      rd_r <= mem[rp_r];
    end else if (rd_ready) begin
      rv_r <= 1'b0;
    end
  end

endmodule : vof_fifo

// [vof_pkg.sv]
// Constants shared by the video output filter and its FIFO.
// Assumes one core clock; users write vof_pkg::name, nothing imported.
//
// Notes on behaviour
// - Raw modes: no codes, timing on pins
// - Dual raw: channel B shares clock, control
// - Filter only in 8-bit video modes
// - Four modes: none, scale, resample, both
// - Horizontal interspersed-to-co-sited chroma only
// - Chroma taps -3, 33, 101, -3 over 128
// - Filtered chroma clamped to 0x01..0xFE
// - Scaling doubles luma and chroma per line
// - Even luma unchanged, odd luma interpolated
// - Co-sited chroma: alternate kept, rest interpolated
// - Interspersed chroma: two coefficient sets
// - Mirror two pixels at each line edge
// - Output pairs: chroma of first luma
package vof_pkg;

  // ----------------------------------------
  // Modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    VOF_D_656_8  = 3'h0,
    VOF_D_656_10 = 3'h1,
    VOF_D_RAW8   = 3'h2,
    VOF_D_RAW10  = 3'h3,
    VOF_D_YC8    = 3'h4,
    VOF_D_YC10   = 3'h5,
    VOF_D_RAW16  = 3'h6,
    VOF_D_RAW20  = 3'h7
  } vof_disp_t;

  typedef enum logic [1:0] {
    VOF_F_NONE   = 2'h0,
    VOF_F_SCALE  = 2'h1,
    VOF_F_RESAMP = 2'h2,
    VOF_F_BOTH   = 2'h3
  } vof_filt_t;

  // Control pin pairs offered in raw display
  typedef enum logic [1:0] {
    VOF_C_SYNC   = 2'h0,
    VOF_C_BLANK  = 2'h1,
    VOF_C_FLDACT = 2'h2,
    VOF_C_VSACT  = 2'h3
  } vof_ctl_t;

  // Output phase of a scaled pair, Gray along A to B
  typedef enum logic {
    VOF_PH_A = 1'b0,
    VOF_PH_B = 1'b1
  } vof_ph_t;

  // Coefficient sets: resample, half-pel, interspersed A and B
  typedef enum logic [1:0] {
    VOF_K_RS = 2'h0,
    VOF_K_HP = 2'h1,
    VOF_K_IA = 2'h2,
    VOF_K_IB = 2'h3
  } vof_kset_t;

  // ----------------------------------------
  // Word layout
  // ----------------------------------------
  localparam int VOF_SW      = 10;
  localparam int VOF_DW      = 40;
  localparam int VOF_QW      = 42;
  localparam int VOF_Y0_LSB  = 0;
  localparam int VOF_Y1_LSB  = 10;
  localparam int VOF_CB_LSB  = 20;
  localparam int VOF_CR_LSB  = 30;
  localparam int VOF_CHB_LSB = 20;
  localparam int VOF_SOL_BIT = 40;
  localparam int VOF_EOL_BIT = 41;
  localparam int VOF_FIFO_DEPTH = 16;
  typedef logic [VOF_SW-1:0] vof_smp_t;

  // ----------------------------------------
  // Filter constants
  // ----------------------------------------
  localparam logic [7:0] VOF_SAT_LO = 8'h01;
  localparam logic [7:0] VOF_SAT_HI = 8'hFE;
  localparam logic [2:0] VOF_SH_128 = 3'h7;
  localparam logic [2:0] VOF_SH_16  = 3'h4;

  // Tap t of set k; sums are 128, except half-pel at 16
  function automatic logic signed [7:0] vof_coef(input vof_kset_t k, input logic [1:0] t);
    logic [31:0] w;
    unique case (k)
      VOF_K_RS: w = 32'hFD2165FD;
      VOF_K_HP: w = 32'hFF0909FF;
      VOF_K_IA: w = 32'hF76F1DFD;
      VOF_K_IB: w = 32'hFD1D6FF7;
    endcase
    return w[8*(3-t) +: 8];
  endfunction : vof_coef

endpackage : vof_pkg

// [vof_sink_model.sv]
// Encoder or DAC model: records pairs, judges line framing.
// Assumes no back-pressure, as the real encoder has none.
module vof_sink_model (
  // Clock and control
  input wire logic        core_clk,
  input wire logic        clr,
  // Pixel pairs from the filter
  input wire logic        out_valid,
  input wire logic [39:0] out_data,
  input wire logic        out_sol,
  input wire logic        out_eol
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] got [0:63];
  int          n_got;
  int          n_frame_err;
  logic        in_line_r;
  // Capture; the array saturates rather than wraps
  always_ff @(posedge core_clk) begin
    if (clr) begin
      n_got <= 0;
    end else if (out_valid && n_got < 64) begin
      got[n_got] <= out_data;
      n_got      <= n_got + 1;
    end
  end
  // A line opens with sol and closes with eol
  always_ff @(posedge core_clk) begin
    if (clr) begin
      in_line_r   <= 1'b0;
      n_frame_err <= 0;
    end else if (out_valid) begin
      if (out_sol == in_line_r) begin
        n_frame_err <= n_frame_err + 1;
      end
      in_line_r <= !out_eol;
    end
  end
endmodule : vof_sink_model

// [vof_video_filter.sv]
// Display-side output filter of a video port.
// Assumes stream, modes and timing come from logic on core_clk.
module vof_video_filter #(
  parameter int DEPTH = vof_pkg::VOF_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // Configuration
  input  wire vof_pkg::vof_disp_t        disp_mode,
  input  wire vof_pkg::vof_filt_t        filt_mode,
  input  wire logic                      dual_en,
  input  wire vof_pkg::vof_ctl_t         ctl_sel,
  // Sample pairs from the output buffers
  input  wire logic                      in_valid,
  input  wire logic [vof_pkg::VOF_DW-1:0] in_data,
  input  wire logic                      in_sol,
  input  wire logic                      in_eol,
  output logic                           in_ready,
  // Frame timing
  input  wire logic                      tim_hsync,
  input  wire logic                      tim_vsync,
  input  wire logic                      tim_hblank,
  input  wire logic                      tim_vblank,
  input  wire logic                      tim_field,
  input  wire logic                      tim_active,
  // To encoder or DAC
  output logic                           out_valid,
  output logic [vof_pkg::VOF_DW-1:0]     out_data,
  output logic                           out_sol,
  output logic                           out_eol,
  output logic [1:0]                     ctl_out
);

  localparam int NS = 5;
  localparam int NY = 10;
  localparam int QW = vof_pkg::VOF_QW;
  localparam int DW = vof_pkg::VOF_DW;
  localparam int SW = vof_pkg::VOF_SW;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic              f_valid;
  logic [QW-1:0]     f_data;
  logic              pop;
  logic [QW-1:0]     win_r [NS];
  logic [QW-1:0]     win_nxt [NS];
  logic [NS-1:0]     wv_r;
  logic [NS-1:0]     wv_nxt;
  vof_pkg::vof_ph_t  ph_r;
  logic              filt_on;
  logic              raw_on;
  logic              scale;
  logic              resamp;
  logic              ctr_rdy;
  logic              last;
  logic              shift;
  int                lo;
  int                hi;
  logic [7:0]        ys [NY];
  logic [7:0]        ym [NY];
  logic [7:0]        cs [2][NS];
  logic [7:0]        cm [2][NS];
  logic [7:0]        y_a;
  logic [7:0]        y_b;
  logic [7:0]        c_o [2];
  logic [DW-1:0]     od;
  logic              out_valid_r;
  logic [DW-1:0]     out_data_r;
  logic              out_sol_r;
  logic              out_eol_r;
  logic [1:0]        ctl_out_r;

  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;
  assign out_sol   = out_sol_r;
  assign out_eol   = out_eol_r;
  assign ctl_out   = ctl_out_r;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Reflect an index into [a, b]; clamp catches very short lines
  function automatic int mir(input int i, input int a, input int b);
    int r;
    r = i;
    if (r < a) begin
      r = 2 * a - r;
    end
    if (r > b) begin
      r = 2 * b - r;
    end
    if (r < a) begin
      r = a;
    end
    return r;
  endfunction : mir

  // Four-tap FIR, shift by set, then clamp
  function automatic logic [7:0] fir(
    input logic [7:0]         a,
    input logic [7:0]         b,
    input logic [7:0]         c,
    input logic [7:0]         d,
    input vof_pkg::vof_kset_t k
  );
    logic signed [17:0] acc;
    logic [2:0]         sh;
    acc = $signed({10'h000, a}) * vof_pkg::vof_coef(k, 2'h0)
        + $signed({10'h000, b}) * vof_pkg::vof_coef(k, 2'h1)
        + $signed({10'h000, c}) * vof_pkg::vof_coef(k, 2'h2)
        + $signed({10'h000, d}) * vof_pkg::vof_coef(k, 2'h3);
    sh = (k == vof_pkg::VOF_K_HP) ? vof_pkg::VOF_SH_16 : vof_pkg::VOF_SH_128;
    acc = acc >>> sh;
    if (acc < $signed({10'h000, vof_pkg::VOF_SAT_LO})) begin
      return vof_pkg::VOF_SAT_LO;
    end
    if (acc > $signed({10'h000, vof_pkg::VOF_SAT_HI})) begin
      return vof_pkg::VOF_SAT_HI;
    end
    return acc[7:0];
  endfunction : fir

  // ----------------------------------------
  // Input buffer
  // ----------------------------------------

  // Scaling drains one pair per two cycles, so this fills and stalls
  vof_fifo #(
    .W     (QW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_valid (in_valid),
    .wr_data  ({in_eol, in_sol, in_data}),
    .wr_ready (in_ready),
    .rd_valid (f_valid),
    .rd_data  (f_data),
    .rd_ready (pop)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------

  // Ten-bit and raw modes bypass every filter
  always_comb begin
    filt_on = (disp_mode == vof_pkg::VOF_D_656_8)
           || (disp_mode == vof_pkg::VOF_D_YC8);
    raw_on  = (disp_mode == vof_pkg::VOF_D_RAW8)
           || (disp_mode == vof_pkg::VOF_D_RAW10)
           || (disp_mode == vof_pkg::VOF_D_RAW16)
           || (disp_mode == vof_pkg::VOF_D_RAW20);
    scale   = filt_on && ((filt_mode == vof_pkg::VOF_F_SCALE)
           || (filt_mode == vof_pkg::VOF_F_BOTH));
    resamp  = filt_on && ((filt_mode == vof_pkg::VOF_F_RESAMP)
           || (filt_mode == vof_pkg::VOF_F_BOTH));
  end

  // ----------------------------------------
  // Pair window
  // ----------------------------------------

  // Slot 2 is the pair being emitted; 0,1 behind, 3,4 ahead.
  // Line edges are found from the start and end flags.
  always_comb begin
    if (win_r[2][vof_pkg::VOF_SOL_BIT] || !wv_r[1]) begin
      lo = 2;
    end else if (win_r[1][vof_pkg::VOF_SOL_BIT] || !wv_r[0]) begin
      lo = 1;
    end else begin
      lo = 0;
    end
    if (win_r[2][vof_pkg::VOF_EOL_BIT]) begin
      hi = 2;
    end else if (win_r[3][vof_pkg::VOF_EOL_BIT]) begin
      hi = 3;
    end else begin
      hi = 4;
    end
  end

  // Filters need two pairs ahead unless the line ends sooner
  always_comb begin
    ctr_rdy = wv_r[2] && (!filt_on || win_r[2][vof_pkg::VOF_EOL_BIT]
           || (wv_r[3] && (win_r[3][vof_pkg::VOF_EOL_BIT] || wv_r[4])));
    last    = !scale || (ph_r == vof_pkg::VOF_PH_B);
    shift   = ctr_rdy && last;
  end

  // Retire the centre pair, then top up the first empty slot
  always_comb begin
    win_nxt = win_r;
    wv_nxt  = wv_r;
    pop     = 1'b0;
    if (shift) begin
      for (int i = 0; i < NS - 1; i++) begin
        win_nxt[i] = win_r[i+1];
        wv_nxt[i]  = wv_r[i+1];
      end
      wv_nxt[NS-1] = 1'b0;
    end
    for (int i = 2; i < NS; i++) begin
      if (!pop && !wv_nxt[i] && f_valid) begin
        win_nxt[i] = f_data;
        wv_nxt[i]  = 1'b1;
        pop        = 1'b1;
      end
    end
  end

  // Window contents
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NS; i++) begin
        win_r[i] <= '0;
      end
      wv_r <= '0;
    end else begin
      win_r <= win_nxt;
      wv_r  <= wv_nxt;
    end
  end

  // Pair phase: scaling emits two output pairs per source pair
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= vof_pkg::VOF_PH_A;
    end else if (ctr_rdy) begin
      if (scale && (ph_r == vof_pkg::VOF_PH_A)) begin
        ph_r <= vof_pkg::VOF_PH_B;
      end else begin
        ph_r <= vof_pkg::VOF_PH_A;
      end
    end
  end

  // ----------------------------------------
  // Samples with edge mirroring
  // ----------------------------------------

  // Missing neighbours beyond an edge take reflected samples
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      ys[2*i]   = win_r[i][vof_pkg::VOF_Y0_LSB +: 8];
      ys[2*i+1] = win_r[i][vof_pkg::VOF_Y1_LSB +: 8];
      cs[0][i]  = win_r[i][vof_pkg::VOF_CB_LSB +: 8];
      cs[1][i]  = win_r[i][vof_pkg::VOF_CR_LSB +: 8];
    end
    for (int i = 0; i < NY; i++) begin
      ym[i] = ys[mir(i, 2 * lo, 2 * hi + 1)];
    end
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < NS; i++) begin
        cm[j][i] = cs[j][mir(i, lo, hi)];
      end
    end
  end

  // ----------------------------------------
  // Filters
  // ----------------------------------------

  // Luma: source on even outputs, half-pel on odd outputs
  always_comb begin
    if (!scale) begin
      y_a = ym[4];
      y_b = ym[5];
    end else if (ph_r == vof_pkg::VOF_PH_A) begin
      y_a = ym[4];
      y_b = fir(ym[3], ym[4], ym[5], ym[6], vof_pkg::VOF_K_HP);
    end else begin
      y_a = ym[5];
      y_b = fir(ym[4], ym[5], ym[6], ym[7], vof_pkg::VOF_K_HP);
    end
  end

  // Chroma per component; one value per output pair
  always_comb begin
    for (int j = 0; j < 2; j++) begin
      c_o[j] = cm[j][2];
      if (scale && resamp) begin
        if (ph_r == vof_pkg::VOF_PH_A) begin
          c_o[j] = fir(cm[j][0], cm[j][1], cm[j][2], cm[j][3],
                       vof_pkg::VOF_K_IA);
        end else begin
          c_o[j] = fir(cm[j][1], cm[j][2], cm[j][3], cm[j][4],
                       vof_pkg::VOF_K_IB);
        end
      end else if (scale) begin
        if (ph_r == vof_pkg::VOF_PH_B) begin
          c_o[j] = fir(cm[j][1], cm[j][2], cm[j][3], cm[j][4],
                       vof_pkg::VOF_K_HP);
        end
      end else if (resamp) begin
        // Horizontal only; vertical 4:2:0 work stays in software
        c_o[j] = fir(cm[j][0], cm[j][1], cm[j][2], cm[j][3],
                     vof_pkg::VOF_K_RS);
      end
    end
  end

  // Assemble the output pair, chroma tied to its first luma
  always_comb begin
    od = win_r[2][DW-1:0];
    if (filt_on) begin
      od[vof_pkg::VOF_Y0_LSB +: SW] = vof_pkg::vof_smp_t'(y_a);
      od[vof_pkg::VOF_Y1_LSB +: SW] = vof_pkg::vof_smp_t'(y_b);
      od[vof_pkg::VOF_CB_LSB +: SW] = vof_pkg::vof_smp_t'(c_o[0]);
      od[vof_pkg::VOF_CR_LSB +: SW] = vof_pkg::vof_smp_t'(c_o[1]);
    end else if (raw_on && !dual_en) begin
      // Channel B idles low unless dual output is on
      od[DW-1:vof_pkg::VOF_CHB_LSB] = '0;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------

  // Raw words pass as assembled above: no timing codes are inserted
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
      out_sol_r   <= 1'b0;
      out_eol_r   <= 1'b0;
    end else begin
      out_valid_r <= ctr_rdy;
      out_sol_r   <= ctr_rdy && (ph_r == vof_pkg::VOF_PH_A)
                  && win_r[2][vof_pkg::VOF_SOL_BIT];
      out_eol_r   <= shift && win_r[2][vof_pkg::VOF_EOL_BIT];
      if (ctr_rdy) begin
        out_data_r <= od;
      end
    end
  end

  // Timing pins in raw display; both channels share them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_out_r <= 2'h0;
    end else if (!raw_on) begin
      ctl_out_r <= 2'h0;
    end else begin
      unique case (ctl_sel)
        vof_pkg::VOF_C_SYNC:   ctl_out_r <= {tim_vsync, tim_hsync};
        vof_pkg::VOF_C_BLANK:  ctl_out_r <= {tim_vblank, tim_hblank};
        vof_pkg::VOF_C_FLDACT: ctl_out_r <= {tim_field, tim_active};
        vof_pkg::VOF_C_VSACT:  ctl_out_r <= {tim_vsync, tim_active};
      endcase
    end
  end

endmodule : vof_video_filter

// [vof_video_filter_properties.sv]
// Port checker for the video output filter, bound to each instance.
// Assumes mode inputs change only while the stream is idle.
module vof_video_filter_properties (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               rst_n,
  // Configuration
  input wire vof_pkg::vof_disp_t disp_mode,
  input wire vof_pkg::vof_filt_t filt_mode,
  input wire logic               dual_en,
  input wire vof_pkg::vof_ctl_t  ctl_sel,
  // Stream and timing
  input wire logic               in_valid,
  input wire logic               in_ready,
  input wire logic               tim_hsync,
  input wire logic               tim_vsync,
  input wire logic               tim_hblank,
  input wire logic               tim_vblank,
  input wire logic               tim_field,
  input wire logic               tim_active,
  input wire logic               out_valid,
  input wire logic [39:0]        out_data,
  input wire logic               out_sol,
  input wire logic               out_eol,
  input wire logic [1:0]         ctl_out
);
  timeunit 1ns / 1ps;
  logic       raw_w;
  logic       vid8_w;
  logic [1:0] sel_w;
  // Raw modes all have bit 1 set; 8-bit video is 0 or 4
  assign raw_w  = disp_mode[1];
  assign vid8_w = (disp_mode[1:0] == 2'h0);
  // Timing pair the selector ought to route
  always_comb begin
    case (ctl_sel)
      vof_pkg::VOF_C_SYNC:   sel_w = {tim_vsync, tim_hsync};
      vof_pkg::VOF_C_BLANK:  sel_w = {tim_vblank, tim_hblank};
      vof_pkg::VOF_C_FLDACT: sel_w = {tim_field, tim_active};
      default:               sel_w = {tim_vsync, tim_active};
    endcase
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_phase_b;
    out_valid && !out_sol;
  endsequence
  sequence s_emit;
    ##[1:8] out_valid;
  endsequence
  a_ctl_raw_route: assert property ($past(rst_n) && $past(raw_w) |-> ctl_out == $past(sel_w))
    else $error("raw control pins not routed");
  a_ctl_video_zero: assert property ($past(rst_n) && !$past(raw_w) |-> ctl_out == 2'h0)
    else $error("control pins active outside raw");
  a_raw_b_clear: assert property (out_valid && raw_w && !dual_en |-> out_data[39:20] == 20'h0)
    else $error("channel B not cleared");
  a_chroma_clamp: assert property (out_valid && vid8_w && filt_mode[1] |->
    out_data[29:20] inside {[10'h001:10'h0FE]} && out_data[39:30] inside {[10'h001:10'h0FE]})
    else $error("chroma outside clamp range");
  a_scale_pair: assert property (out_sol && vid8_w && filt_mode[0] |=> s_phase_b)
    else $error("scaled pair lacks second half");
  a_scale_tail: assert property (out_eol && vid8_w && filt_mode[0] |-> $past(out_valid))
    else $error("scaled line ends on half pair");
  a_bypass_flow: assert property (in_valid && in_ready && !vid8_w |-> s_emit)
    else $error("bypass word not emitted");
  a_frame_marks: assert property (out_sol || out_eol |-> out_valid)
    else $error("line mark without valid");
  a_reset_quiet: assert property (!$past(rst_n) |-> in_ready && !out_valid && ctl_out == 2'h0)
    else $error("outputs busy after reset");
endmodule : vof_video_filter_properties

bind vof_video_filter vof_video_filter_properties u_props (.core_clk, .rst_n, .disp_mode,
  .filt_mode, .dual_en, .ctl_sel, .in_valid, .in_ready, .tim_hsync, .tim_vsync, .tim_hblank,
  .tim_vblank, .tim_field, .tim_active, .out_valid, .out_data, .out_sol, .out_eol, .ctl_out);

// [vof_video_filter_tb_top.sv]
// Self-checking bench of the video output filter and a sink.
// Assumes FIFO depth 4 so that scaled traffic fills it.
module vof_video_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk;
  logic                 rst_n;
  logic                 clr;
  vof_pkg::vof_disp_t   disp_mode;
  vof_pkg::vof_filt_t   filt_mode;
  logic                 dual_en;
  vof_pkg::vof_ctl_t    ctl_sel;
  logic                 in_valid;
  logic [39:0]          in_data;
  logic                 in_sol;
  logic                 in_eol;
  logic                 in_ready;
  logic [5:0]           tim_r;
  logic                 out_valid;
  logic [39:0]          out_data;
  logic                 out_sol;
  logic                 out_eol;
  logic [1:0]           ctl_out;
  logic [39:0]          src [0:15];
  int                   n_fail;
  int                   n_tests;
  int                   n_stall;
  vof_video_filter #(.DEPTH(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .disp_mode(disp_mode), .filt_mode(filt_mode), .dual_en(dual_en), .ctl_sel(ctl_sel),
    .in_valid(in_valid), .in_data(in_data), .in_sol(in_sol), .in_eol(in_eol),
    .in_ready(in_ready), .tim_vsync(tim_r[5]), .tim_hsync(tim_r[4]), .tim_vblank(tim_r[3]),
    .tim_hblank(tim_r[2]), .tim_field(tim_r[1]), .tim_active(tim_r[0]),
    .out_valid(out_valid), .out_data(out_data), .out_sol(out_sol), .out_eol(out_eol),
    .ctl_out(ctl_out));
  vof_sink_model sink (.core_clk(core_clk), .clr(clr), .out_valid(out_valid),
    .out_data(out_data), .out_sol(out_sol), .out_eol(out_eol));

  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  function automatic logic [39:0] pk(input logic [7:0] y0, y1, cb, cr);
    return {2'h0, cr, 2'h0, cb, 2'h0, y1, 2'h0, y0};
  endfunction : pk

  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Mode change only while idle; sink cleared alongside
  task automatic cfg(input vof_pkg::vof_disp_t d, input vof_pkg::vof_filt_t f, input logic de,
                     input vof_pkg::vof_ctl_t cs);
    @(posedge core_clk);
    disp_mode <= d;
    filt_mode <= f;
    dual_en   <= de;
    ctl_sel   <= cs;
    clr       <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : cfg

  // Holds the word until in_ready is seen high at an edge
  task automatic send(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_data  <= src[i];
      in_sol   <= (i == 0);
      in_eol   <= (i == n - 1);
      k = 0;
      do begin
        @(posedge core_clk);
        if (in_ready !== 1'b1) n_stall++;
        k++;
      end while (in_ready !== 1'b1 && k < 100);
    end
    in_valid <= 1'b0;
  endtask : send

  task automatic collect(input int n);
    int k;
    k = 0;
    while (sink.n_got < n && k < 300) begin
      @(posedge core_clk);
      k++;
    end
    repeat (8) @(posedge core_clk);
    chk("pair count", 40'(n), 40'(sink.n_got));
  endtask : collect

  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  task automatic t_bypass();
    cfg(vof_pkg::VOF_D_656_8, vof_pkg::VOF_F_NONE, 1'b0, vof_pkg::VOF_C_SYNC);
    src[0] = pk(8'h11, 8'h22, 8'h33, 8'h44);
    src[1] = pk(8'h55, 8'h66, 8'h77, 8'h88);
    send(2);
    collect(2);
    chk("plain pair 0", src[0], sink.got[0]);
    chk("plain pair 1", src[1], sink.got[1]);
    cfg(vof_pkg::VOF_D_YC10, vof_pkg::VOF_F_BOTH, 1'b0, vof_pkg::VOF_C_SYNC);
    src[0] = 40'hFFC0_1556_AB;
    send(1);
    collect(1);
    chk("10-bit pair", src[0], sink.got[0]);
    $display("bypass done");
  endtask : t_bypass

  task automatic t_raw();
    logic [1:0] e;
    for (int c = 0; c < 4; c++) begin
      cfg(vof_pkg::VOF_D_RAW16, vof_pkg::VOF_F_BOTH, c[0], vof_pkg::vof_ctl_t'(c));
      src[0] = 40'hA5C3_96E1_7B;
      send(1);
      collect(1);
      chk("raw word", c[0] ? src[0] : {20'h0, src[0][19:0]}, sink.got[0]);
      for (int p = 0; p < 2; p++) begin
        tim_r <= p ? 6'h1A : 6'h25;
        repeat (2) @(posedge core_clk);
        e = (c == 0) ? tim_r[5:4] : (c == 1) ? tim_r[3:2] : (c == 2) ? tim_r[1:0]
          : {tim_r[5], tim_r[0]};
        chk("control pins", 40'(e), 40'(ctl_out));
      end
    end
    $display("raw done");
  endtask : t_raw

  task automatic t_resamp();
    cfg(vof_pkg::VOF_D_YC8, vof_pkg::VOF_F_RESAMP, 1'b0, vof_pkg::VOF_C_SYNC);
    src[0] = pk(8'h10, 8'h20, 8'h00, 8'hFF);
    send(1);
    collect(1);
    chk("clamped chroma", {2'h0, 8'hFE, 2'h0, 8'h01}, 40'(sink.got[0][39:20]));
    cfg(vof_pkg::VOF_D_YC8, vof_pkg::VOF_F_RESAMP, 1'b0, vof_pkg::VOF_C_SYNC);
    src[0] = pk(8'h10, 8'h20, 8'h10, 8'h10);
    src[1] = pk(8'h30, 8'h40, 8'h90, 8'h90);
    send(2);
    collect(2);
    chk("chroma 0", {2'h0, 8'h2E, 2'h0, 8'h2E}, 40'(sink.got[0][39:20]));
    chk("chroma 1", {2'h0, 8'h72, 2'h0, 8'h72}, 40'(sink.got[1][39:20]));
    $display("resample done");
  endtask : t_resamp

  task automatic t_scale();
    cfg(vof_pkg::VOF_D_656_8, vof_pkg::VOF_F_SCALE, 1'b0, vof_pkg::VOF_C_SYNC);
    src[0] = pk(8'h20, 8'h60, 8'h50, 8'h50);
    send(1);
    collect(2);
    chk("phase A", pk(8'h20, 8'h40, 8'h50, 8'h50), sink.got[0]);
    chk("phase B", pk(8'h60, 8'h44, 8'h50, 8'h50), sink.got[1]);
    cfg(vof_pkg::VOF_D_YC8, vof_pkg::VOF_F_BOTH, 1'b0, vof_pkg::VOF_C_SYNC);
    src[0] = pk(8'h70, 8'h70, 8'h70, 8'h70);
    src[1] = src[0];
    send(2);
    collect(4);
    for (int i = 0; i < 4; i++) chk("flat pair", src[0], sink.got[i]);
    $display("scale done");
  endtask : t_scale

  // Scaled output drains at half rate, so the FIFO must refuse
  task automatic t_fill();
    cfg(vof_pkg::VOF_D_656_8, vof_pkg::VOF_F_SCALE, 1'b0, vof_pkg::VOF_C_SYNC);
    for (int i = 0; i < 16; i++) src[i] = pk(8'h33, 8'h33, 8'h33, 8'h33);
    n_stall = 0;
    send(16);
    collect(32);
    chk("input refused", 40'h1, 40'(n_stall > 0));
    chk("last pair", src[0], sink.got[31]);
    chk("framing errors", 40'h0, 40'(sink.n_frame_err));
    $display("fill done");
  endtask : t_fill

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // --------------------------------------------------
  // Clock, reset, sequence and watchdog
  // --------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    rst_n     = 1'b0;
    clr       = 1'b0;
    disp_mode = vof_pkg::VOF_D_656_8;
    filt_mode = vof_pkg::VOF_F_NONE;
    dual_en   = 1'b0;
    ctl_sel   = vof_pkg::VOF_C_SYNC;
    in_valid  = 1'b0;
    in_data   = 40'h0;
    in_sol    = 1'b0;
    in_eol    = 1'b0;
    tim_r     = 6'h0;
    n_fail    = 0;
    n_tests   = 0;
    n_stall   = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_bypass();
    t_raw();
    t_resamp();
    t_scale();
    t_fill();
    complete_run();
  end

  // Run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("BAD watchdog expected finish seen hang");
    complete_run();
  end
endmodule : vof_video_filter_tb_top
